// ===== hw/pgdr_pkg.sv
// Purpose: shared constants for the power-good delay, ramp gain and fault mask bank
// Assumes: command codes arrive on a byte-wide code port, data words are 16 bits
// Notes:   times are kept in their own unit and turned into cycle counts here
package pgdr_pkg;

    // command codes of the three settings
    localparam logic [7:0]  CMD_PGOOD_DELAY     = 8'hd4;
    localparam logic [7:0]  CMD_RAMP_GAIN       = 8'hd5;
    localparam logic [7:0]  CMD_FAULT_MASK      = 8'hd7;

    // reset values
    localparam logic [15:0] PGOOD_DELAY_RESET   = 16'hba00;  // one millisecond
    localparam logic [7:0]  RAMP_GAIN_RESET     = 8'h03;
    localparam logic [15:0] FAULT_MASK_RESET    = 16'h0000;

    // delay word layout: exponent on top, mantissa below
    localparam int          EXP_MSB             = 15;
    localparam int          EXP_LSB             = 11;
    localparam int          MAN_MSB             = 10;

    // output pages
    localparam int          NUM_PAGES           = 2;

    // fault mask bit positions
    localparam int          FM_SPREAD           = 13;
    localparam int          FM_OTHER_PHASE      = 12;
    localparam int          FM_PROCESSOR        = 11;
    localparam int          FM_CHECKSUM         = 10;
    localparam int          FM_OUT_UC           = 7;
    localparam int          FM_OUT_OC           = 6;
    localparam int          FM_IN_UV            = 5;
    localparam int          FM_IN_OV            = 4;
    localparam int          FM_UNDER_TEMP       = 3;
    localparam int          FM_OVER_TEMP        = 2;
    localparam int          FM_OUT_UV           = 1;
    localparam int          FM_OUT_OV           = 0;
    localparam logic [15:0] FAULT_USED_BITS     = 16'h3cff;  // 15:14, 9, 8 unused

    // timer resolution and clock
    localparam int          TICK_NS             = 125;
    localparam int          CLK_PERIOD_NS       = 4;
    localparam int          TICK_CYCLES         = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          TICKS_PER_MS        = 1000000 / TICK_NS;
    localparam int          MAX_DELAY_MS        = 500;
    localparam int          MAX_DELAY_TICKS     = MAX_DELAY_MS * TICKS_PER_MS;
    localparam int          TICK_W              = 22;
    localparam int          DIV_W               = 16;

    // phases-in-rail field holds count minus one
    localparam logic [2:0]  RAIL_FOUR_PHASE     = 3'h3;

    // per-output power-good sequencer states
    typedef enum logic [2:0] {
        SEQ_IDLE  = 3'b001,
        SEQ_COUNT = 3'b010,
        SEQ_GOOD  = 3'b100
    } pgdr_seq_state_e;

endpackage

// ===== hw/pgdr_page_store.sv
// Purpose: per-page storage of the power-good delay word
// Assumes: one write port, one registered read port
// Notes:   all words also leave directly from their storage flops for the timers
`timescale 1ns/1ps
module pgdr_page_store
    import pgdr_pkg::*;
(
    // clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        reset,
    // write port
    input  wire logic                        wrEn,
    input  wire logic [0:0]                  wrPage,
    input  wire logic [15:0]                 wrData,
    // read port
    input  wire logic [0:0]                  rdPage,
    output logic      [15:0]                 rdData,
    // all stored words
    output logic      [NUM_PAGES-1:0][15:0]  allWords
);
    logic [NUM_PAGES-1:0][15:0] word_q;
    logic [NUM_PAGES-1:0][15:0] word_d;
    logic [15:0]                rdData_q;
    logic [15:0]                rdData_d;

    // write and read selection
    always_comb
    begin
        word_d           = word_q;
        if (wrEn)
        begin
            word_d[wrPage] = wrData;
        end
        rdData_d         = word_q[rdPage];
    end

    // storage, loaded with the one millisecond default
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            word_q   <= {NUM_PAGES{PGOOD_DELAY_RESET}};
            rdData_q <= 16'h0000;
        end
        else
        begin
            word_q   <= word_d;
            rdData_q <= rdData_d;
        end
    end

    assign rdData   = rdData_q;
    assign allWords = word_q;

endmodule // pgdr_page_store

// ===== hw/pgdr_regs.sv
// Purpose: power-good delay timers, start-up ramp gain mode control, fault capture mask
// Assumes: one command at a time on the code port; status inputs synchronous to clk_sys
// Notes:   reads answer two cycles after the request; writes take effect next cycle
`timescale 1ns/1ps

module pgdr_regs
    import pgdr_pkg::*;
#(
    parameter int TICK_DIV  = TICK_CYCLES,
    parameter int MAX_TICKS = MAX_DELAY_TICKS
)
(
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 reset,
    // command port from the management bus
    input  wire logic                 cmdWrite,
    input  wire logic                 cmdRead,
    input  wire logic [7:0]           cmdCode,
    input  wire logic [0:0]           cmdPage,
    input  wire logic [15:0]          cmdWrData,
    output logic      [15:0]          cmdRdData_q,
    output logic                      cmdRdValid_q,
    output logic                      cmdError_q,
    // regulation status
    input  wire logic [NUM_PAGES-1:0] outputAboveOn,
    input  wire logic [NUM_PAGES-1:0] outputEnable,
    input  wire logic [2:0]           phasesInRail,
    // fault sources, one bit per mask position
    input  wire logic [15:0]          faultEvents,
    // control outputs
    output logic [NUM_PAGES-1:0]      power_good_pin_q,
    output logic [NUM_PAGES-1:0]      adaptiveCompEn_q,
    output logic                      multiPhaseMode_q,
    output logic                      softOffAllowed_q,
    output logic                      turnOffFallUsed_q,
    output logic [NUM_PAGES-1:0]      highSideDriveOe_q,
    output logic [NUM_PAGES-1:0]      lowSideForceLow_q,
    output logic [7:0]                rampGain_q,
    output logic                      faultCaptureEvent_q,
    output logic [15:0]               faultCaptureSource_q
);
    import pgdr_pkg::*;

    // delay word to timer ticks, negative or zero mantissa gives zero
    function automatic logic [TICK_W-1:0] delayTicks(input logic [15:0] word);
        logic signed [4:0]  expo;
        logic signed [10:0] man;
        logic        [39:0] prod;
        logic        [39:0] scaled;
        expo   = signed'(word[EXP_MSB:EXP_LSB]);
        man    = signed'(word[MAN_MSB:0]);
        prod   = 40'(man[9:0]) * 40'(TICKS_PER_MS);
        if (expo < 0)
        begin
            scaled = prod >> 5'(-expo);
        end
        else
        begin
            scaled = prod << 5'(expo);
        end
        if (man <= 0)
        begin
            scaled = 40'h0;
        end
        if (scaled > 40'(MAX_TICKS))
        begin
            scaled = 40'(MAX_TICKS);
        end
        return scaled[TICK_W-1:0];
    endfunction

    // code decode, used on both the write and read paths
    function automatic logic isMapped(input logic [7:0] code);
        return (code == CMD_PGOOD_DELAY) || (code == CMD_RAMP_GAIN) ||
               (code == CMD_FAULT_MASK);
    endfunction

    // delay storage per page
    logic                        delayWrEn;
    logic [15:0]                 delayRdData;
    logic [NUM_PAGES-1:0][15:0]  delayWords;

    assign delayWrEn = cmdWrite && (cmdCode == CMD_PGOOD_DELAY);

    pgdr_page_store u_store
    (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .wrEn     (delayWrEn),
        .wrPage   (cmdPage),
        .wrData   (cmdWrData),
        .rdPage   (cmdPage),
        .rdData   (delayRdData),
        .allWords (delayWords)
    );

    // global settings and command answer
    logic [7:0]  gain_d;
    logic [15:0] faultMask_q;
    logic [15:0] faultMask_d;
    logic        rdPend_q;
    logic        rdPend_d;
    logic        accErr_q;
    logic        accErr_d;
    logic [7:0]  rdCode_q;
    logic [7:0]  rdCode_d;
    logic [15:0] rdData_d;
    logic        rdValid_d;
    logic        error_d;

    always_comb
    begin
        gain_d      = rampGain_q;
        faultMask_d = faultMask_q;
        rdPend_d    = 1'b0;
        accErr_d    = 1'b0;
        rdCode_d    = rdCode_q;
        if (cmdWrite)
        begin
            if (cmdCode == CMD_RAMP_GAIN)
            begin
                gain_d = cmdWrData[7:0];
            end
            if (cmdCode == CMD_FAULT_MASK)
            begin
                faultMask_d = cmdWrData;
            end
            accErr_d = !isMapped(cmdCode);
        end
        else if (cmdRead)
        begin
            rdPend_d = isMapped(cmdCode);
            accErr_d = !isMapped(cmdCode);
            rdCode_d = cmdCode;
        end
        // second stage: select the answer word
        rdValid_d = rdPend_q;
        error_d   = accErr_q;
        rdData_d  = cmdRdData_q;
        if (rdPend_q)
        begin
            case (rdCode_q)
                CMD_PGOOD_DELAY: rdData_d = delayRdData;
                CMD_RAMP_GAIN:  rdData_d = {8'h00, rampGain_q};
                CMD_FAULT_MASK: rdData_d = faultMask_q;
                default:        rdData_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            rampGain_q   <= RAMP_GAIN_RESET;
            faultMask_q  <= FAULT_MASK_RESET;
            rdPend_q     <= 1'b0;
            accErr_q     <= 1'b0;
            rdCode_q     <= 8'h00;
            cmdRdData_q  <= 16'h0000;
            cmdRdValid_q <= 1'b0;
            cmdError_q   <= 1'b0;
        end
        else
        begin
            rampGain_q   <= gain_d;
            faultMask_q  <= faultMask_d;
            rdPend_q     <= rdPend_d;
            accErr_q     <= accErr_d;
            rdCode_q     <= rdCode_d;
            cmdRdData_q  <= rdData_d;
            cmdRdValid_q <= rdValid_d;
            cmdError_q   <= error_d;
        end
    end

    // 128 ns timer step from the system clock (125 ns rounded up to 32 cycles)
    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] div_d;
    logic             tick;

    always_comb
    begin
        tick  = (div_q == DIV_W'(TICK_DIV - 1));
        div_d = tick ? '0 : div_q + 1'b1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            div_q <= '0;
        end
        else
        begin
            div_q <= div_d;
        end
    end

    // power-good sequencer per output page
    pgdr_seq_state_e [NUM_PAGES-1:0]              seqState_q;
    pgdr_seq_state_e [NUM_PAGES-1:0]              seqState_d;
    logic            [NUM_PAGES-1:0][TICK_W-1:0] seqCount_q;
    logic            [NUM_PAGES-1:0][TICK_W-1:0] seqCount_d;
    logic            [NUM_PAGES-1:0]             goodPin_d;

    always_comb
    begin
        for (int p = 0; p < NUM_PAGES; p++)
        begin
            seqState_d[p] = seqState_q[p];
            seqCount_d[p] = seqCount_q[p];
            case (seqState_q[p])
                SEQ_IDLE:
                begin
                    if (outputAboveOn[p])
                    begin
                        seqCount_d[p] = delayTicks(delayWords[p]);
                        seqState_d[p] = SEQ_COUNT;
                    end
                end
                SEQ_COUNT:
                begin
                    if (!outputAboveOn[p])
                    begin
                        seqState_d[p] = SEQ_IDLE;
                    end
                    else if (seqCount_q[p] == '0)
                    begin
                        seqState_d[p] = SEQ_GOOD;
                    end
                    else if (tick)
                    begin
                        seqCount_d[p] = seqCount_q[p] - 1'b1;
                    end
                end
                SEQ_GOOD:
                begin
                    if (!outputAboveOn[p])
                    begin
                        seqState_d[p] = SEQ_IDLE;
                    end
                end
                default: seqState_d[p] = SEQ_IDLE;
            endcase
            goodPin_d[p] = (seqState_d[p] == SEQ_GOOD);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            seqState_q       <= '{default: SEQ_IDLE};
            seqCount_q       <= '0;
            power_good_pin_q <= '0;
        end
        else
        begin
            seqState_q       <= seqState_d;
            seqCount_q       <= seqCount_d;
            power_good_pin_q <= goodPin_d;
        end
    end

    // ramp mode: compensation, soft-off and shutdown drive control
    logic                 mpMode_d;
    logic [NUM_PAGES-1:0] comp_d;
    logic [NUM_PAGES-1:0] hsOe_d;
    logic [NUM_PAGES-1:0] lsLow_d;

    always_comb
    begin
        mpMode_d = (phasesInRail == RAIL_FOUR_PHASE);
        for (int p = 0; p < NUM_PAGES; p++)
        begin
            // standalone keeps compensation on; multiphase waits for power-good
            comp_d[p]  = !mpMode_d || goodPin_d[p];
            hsOe_d[p]  = !(mpMode_d && !outputEnable[p]);
            lsLow_d[p] = mpMode_d && !outputEnable[p];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            multiPhaseMode_q  <= 1'b0;
            softOffAllowed_q  <= 1'b1;
            turnOffFallUsed_q <= 1'b1;
            adaptiveCompEn_q  <= '1;
            highSideDriveOe_q <= '1;
            lowSideForceLow_q <= '0;
        end
        else
        begin
            multiPhaseMode_q  <= mpMode_d;
            softOffAllowed_q  <= !mpMode_d;
            turnOffFallUsed_q <= !mpMode_d;
            adaptiveCompEn_q  <= comp_d;
            highSideDriveOe_q <= hsOe_d;
            lowSideForceLow_q <= lsLow_d;
        end
    end
    // rampGain_q feeds the ramp generator, whose slope scales with it

    // fault capture trigger on new, unmasked, used fault bits
    logic [15:0] faultPrev_q;
    logic [15:0] newFaults;

    always_comb
    begin
        newFaults = faultEvents & ~faultPrev_q & ~faultMask_q & FAULT_USED_BITS;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            faultPrev_q          <= 16'h0000;
            faultCaptureEvent_q  <= 1'b0;
            faultCaptureSource_q <= 16'h0000;
        end
        else
        begin
            faultPrev_q          <= faultEvents;
            faultCaptureEvent_q  <= |newFaults;
            faultCaptureSource_q <= newFaults;
        end
    end

endmodule // pgdr_regs

// ===== verification/pgdr_regs_checker.sv
// Purpose: concurrent checks on the settings bank ports
// Assumes: bound to pgdr_regs, one clock domain
// Notes:   keeps a shadow of the capture mask from observed writes
`timescale 1ns/1ps
module pgdr_regs_checker
    import pgdr_pkg::*;
(
    // clock and reset
    input wire logic                 clk_sys,
    input wire logic                 reset,
    // command port
    input wire logic                 cmdWrite,
    input wire logic                 cmdRead,
    input wire logic [7:0]           cmdCode,
    input wire logic [15:0]          cmdWrData,
    input wire logic                 cmdRdValid_q,
    input wire logic                 cmdError_q,
    // status and controls
    input wire logic [NUM_PAGES-1:0] outputAboveOn,
    input wire logic [NUM_PAGES-1:0] outputEnable,
    input wire logic [2:0]           phasesInRail,
    input wire logic [15:0]          faultEvents,
    input wire logic [NUM_PAGES-1:0] power_good_pin_q,
    input wire logic [NUM_PAGES-1:0] adaptiveCompEn_q,
    input wire logic                 multiPhaseMode_q,
    input wire logic                 softOffAllowed_q,
    input wire logic                 turnOffFallUsed_q,
    input wire logic [NUM_PAGES-1:0] highSideDriveOe_q,
    input wire logic [NUM_PAGES-1:0] lowSideForceLow_q,
    input wire logic [7:0]           rampGain_q,
    input wire logic                 faultCaptureEvent_q,
    input wire logic [15:0]          faultCaptureSource_q
);
    logic [15:0] maskShadow_d;
    logic [15:0] maskShadow_q;
    logic        mapped;
    // shadow mask follows whole-word writes
    always_comb
    begin
        maskShadow_d = maskShadow_q;
        if (cmdWrite && cmdCode == CMD_FAULT_MASK)
            maskShadow_d = cmdWrData;
    end
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            maskShadow_q <= FAULT_MASK_RESET;
        else
            maskShadow_q <= maskShadow_d;
    end
    assign mapped = cmdCode inside {CMD_PGOOD_DELAY, CMD_RAMP_GAIN, CMD_FAULT_MASK};
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // read request and its answer
    sequence rdReq;
        cmdRead && !cmdWrite && mapped;
    endsequence
    sequence rdAnswer;
        ##2 cmdRdValid_q && !cmdError_q;
    endsequence
    // an unmasked, used fault level rose
    sequence faultRise;
        |(faultEvents & ~$past(faultEvents) & ~maskShadow_q & FAULT_USED_BITS);
    endsequence
    a_read_answer: assert property (rdReq |-> rdAnswer)
        else $error("read got no answer");
    a_good_hold: assert property (power_good_pin_q[0] |-> $past(outputAboveOn[0]))
        else $error("power good without threshold");
    a_good_delay: assert property ($rose(power_good_pin_q[1]) |->
        $past(outputAboveOn[1], 1) && $past(outputAboveOn[1], 2))
        else $error("power good too early");
    a_mode_select: assert property (##1 multiPhaseMode_q == $past(phasesInRail == 3'h3))
        else $error("ramp mode wrong");
    a_no_soft_off: assert property (multiPhaseMode_q |-> !softOffAllowed_q && !turnOffFallUsed_q)
        else $error("soft off in ramp mode");
    a_comp_after_pg: assert property (multiPhaseMode_q |-> adaptiveCompEn_q == power_good_pin_q)
        else $error("compensation before power good");
    a_standalone_comp: assert property (!multiPhaseMode_q |->
        adaptiveCompEn_q == 2'b11 && softOffAllowed_q && turnOffFallUsed_q)
        else $error("standalone settings wrong");
    a_mp_shutdown: assert property (phasesInRail == 3'h3 && !outputEnable[0] |=>
        !highSideDriveOe_q[0] && lowSideForceLow_q[0])
        else $error("shutdown drive wrong");
    a_capture_rise: assert property (faultRise |=> faultCaptureEvent_q)
        else $error("capture missed");
    a_capture_masked: assert property (faultCaptureEvent_q |->
        (faultCaptureSource_q & (maskShadow_q | ~FAULT_USED_BITS)) == 16'h0000)
        else $error("masked fault captured");
    a_gain_reset: assert property ($fell(reset) |-> rampGain_q == RAMP_GAIN_RESET)
        else $error("gain reset wrong");
endmodule // pgdr_regs_checker

bind pgdr_regs pgdr_regs_checker i_chk (.clk_sys(clk_sys), .reset(reset),
    .cmdWrite(cmdWrite), .cmdRead(cmdRead), .cmdCode(cmdCode), .cmdWrData(cmdWrData),
    .cmdRdValid_q(cmdRdValid_q), .cmdError_q(cmdError_q), .outputAboveOn(outputAboveOn),
    .outputEnable(outputEnable), .phasesInRail(phasesInRail), .faultEvents(faultEvents),
    .power_good_pin_q(power_good_pin_q), .adaptiveCompEn_q(adaptiveCompEn_q),
    .multiPhaseMode_q(multiPhaseMode_q), .softOffAllowed_q(softOffAllowed_q),
    .turnOffFallUsed_q(turnOffFallUsed_q), .highSideDriveOe_q(highSideDriveOe_q),
    .lowSideForceLow_q(lowSideForceLow_q), .rampGain_q(rampGain_q),
    .faultCaptureEvent_q(faultCaptureEvent_q), .faultCaptureSource_q(faultCaptureSource_q));

// ===== verification/pgdr_host_model.sv
// Purpose: management bus host issuing one command at a time
// Assumes: called 1 ns after a rising edge
// Notes:   released code, page and data lines show the inverse of their last value; write and read drop to 0
`timescale 1ns/1ps
module pgdr_host_model
(
    // clock
    input  wire logic        clk_sys,
    // command port
    output logic             cmdWrite,
    output logic             cmdRead,
    output logic [7:0]       cmdCode,
    output logic [0:0]       cmdPage,
    output logic [15:0]      cmdWrData,
    // answers
    input  wire logic [15:0] cmdRdData_q,
    input  wire logic        cmdRdValid_q,
    input  wire logic        cmdError_q
);
    // idle until the first command
    initial
    begin
        cmdWrite  = 1'b0;
        cmdRead   = 1'b0;
        cmdCode   = 8'h00;
        cmdPage   = 1'b0;
        cmdWrData = 16'h0000;
    end
    // request held over its taking edge, answer taken two edges on
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [0:0] page,
        input logic [15:0] data, output logic [15:0] rdData, output logic rdValid,
        output logic rdErr);
        cmdWrite  = wr;
        cmdRead   = !wr;
        cmdCode   = code;
        cmdPage   = page;
        cmdWrData = data;
        @(posedge clk_sys);
        #1;
        cmdWrite  = 1'b0;
        cmdRead   = 1'b0;
        cmdCode   = ~code;
        cmdPage   = ~page;
        cmdWrData = ~data;
        @(posedge clk_sys);
        #1;
        rdData  = cmdRdData_q;
        rdValid = cmdRdValid_q;
        rdErr   = cmdError_q;
    endtask
endmodule // pgdr_host_model

// ===== verification/tb_pgdr_regs.sv
// Purpose: self-checking bench for the settings bank
// Assumes: short timer parameters, host model on the command port
// Notes:   expectations come from an integer model kept here
`timescale 1ns/1ps
module tb_pgdr_regs;
    import pgdr_pkg::*;
    localparam int DIV  = 1;
    localparam int MAXT = 64;
    logic        clk_sys       = 1'b0;
    logic        reset         = 1'b1;
    logic [1:0]  outputAboveOn = 2'b00;
    logic [1:0]  outputEnable  = 2'b11;
    logic [2:0]  phasesInRail  = 3'h1;
    logic [15:0] faultEvents   = 16'h0000;
    logic        cmdWrite, cmdRead, cmdRdValid_q, cmdError_q, v, e;
    logic        mpMode, softOff, fallUsed, capEv;
    logic [7:0]  cmdCode, gain;
    logic [0:0]  cmdPage;
    logic [15:0] cmdWrData, cmdRdData_q, capSrc, q;
    logic [1:0]  goodPin, comp, hsOe, lsLow;
    int          fails        = 0;
    int          total_checks = 0;
    int          model[4];
    logic [7:0]  codes[4]     = '{CMD_PGOOD_DELAY, CMD_PGOOD_DELAY, CMD_RAMP_GAIN, CMD_FAULT_MASK};
    // 250 MHz clock
    always #2 clk_sys = ~clk_sys;
    pgdr_host_model i_host (.clk_sys(clk_sys), .cmdWrite(cmdWrite), .cmdRead(cmdRead),
        .cmdCode(cmdCode), .cmdPage(cmdPage), .cmdWrData(cmdWrData),
        .cmdRdData_q(cmdRdData_q), .cmdRdValid_q(cmdRdValid_q), .cmdError_q(cmdError_q));
    pgdr_regs #(.TICK_DIV(DIV), .MAX_TICKS(MAXT)) i_dut (.clk_sys(clk_sys), .reset(reset),
        .cmdWrite(cmdWrite), .cmdRead(cmdRead), .cmdCode(cmdCode), .cmdPage(cmdPage),
        .cmdWrData(cmdWrData), .cmdRdData_q(cmdRdData_q), .cmdRdValid_q(cmdRdValid_q),
        .cmdError_q(cmdError_q), .outputAboveOn(outputAboveOn), .outputEnable(outputEnable),
        .phasesInRail(phasesInRail), .faultEvents(faultEvents), .power_good_pin_q(goodPin),
        .adaptiveCompEn_q(comp), .multiPhaseMode_q(mpMode), .softOffAllowed_q(softOff),
        .turnOffFallUsed_q(fallUsed), .highSideDriveOe_q(hsOe), .lowSideForceLow_q(lsLow),
        .rampGain_q(gain), .faultCaptureEvent_q(capEv), .faultCaptureSource_q(capSrc));
    // compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // verdict and end of run
    task automatic complete_run();
        if (fails == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // delay word to timer steps, clamped
    function automatic int ticks(input logic [15:0] w);
        longint t;
        int     x;
        x = int'($signed(w[15:11]));
        t = longint'($signed(w[10:0])) * TICKS_PER_MS;
        t = (x < 0) ? t >>> (-x) : t <<< x;
        return (t <= 0) ? 0 : (t > MAXT) ? MAXT : int'(t);
    endfunction
    // slot k: delay page 0, delay page 1, gain, mask
    task automatic rd(input int k);
        i_host.xfer(1'b0, codes[k], 1'(k == 1), 16'h0000, q, v, e);
        chk(16'({v, e}), 16'h2);
        chk(q, 16'(model[k]));
    endtask
    task automatic wr(input int k, input logic [15:0] d);
        i_host.xfer(1'b1, codes[k], 1'(k == 1), d, q, v, e);
        model[k] = (k == 2) ? int'(d[7:0]) : int'(d);
    endtask
    // both pages rise together, time to each power-good pin
    task automatic good_time(input logic [15:0] w0, input logic [15:0] w1);
        int n[2];
        int t;
        wr(0, w0);
        wr(1, w1);
        n = '{0, 0};
        outputAboveOn = 2'b11;
        for (int c = 1; c < 200 && (n[0] == 0 || n[1] == 0); c++)
        begin
            @(posedge clk_sys);
            #1;
            for (int p = 0; p < 2; p++)
                if (goodPin[p] === 1'b1 && n[p] == 0)
                    n[p] = c;
        end
        if (n[0] == 0 || n[1] == 0)
        begin
            chk(16'h0000, 16'h0001);
            complete_run();
        end
        for (int p = 0; p < 2; p++)
        begin
            t = ticks(p ? w1 : w0);
            chk(16'(t == 0 ? n[p] == 2 : n[p] >= t*DIV-DIV && n[p] <= t*DIV+DIV+3), 16'h1);
        end
        chk(16'(comp), 16'h3);
        outputAboveOn = 2'b00;
        @(posedge clk_sys);
        #1;
        chk(16'(goodPin), 16'h0);
    endtask
    // main sequence
    initial
    begin
        model = '{PGOOD_DELAY_RESET, PGOOD_DELAY_RESET, RAMP_GAIN_RESET, FAULT_MASK_RESET};
        q = 16'($urandom(5));
        repeat (5) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        for (int k = 0; k < 4; k++)
            rd(k);
        // unmapped code refused both ways
        i_host.xfer(1'b1, 8'hd6, 1'b0, 16'hffff, q, v, e);
        chk(16'({v, e}), 16'h1);
        i_host.xfer(1'b0, 8'hd6, 1'b0, 16'h0000, q, v, e);
        chk(16'({v, e}), 16'h1);
        // random whole-word writes, every slot read back
        for (int i = 0; i < 12; i++)
        begin
            wr(int'($urandom % 4), 16'($urandom));
            for (int k = 0; k < 4; k++)
                rd(k);
        end
        chk(16'(gain), 16'(model[2]));
        // every phases-in-rail value, page 0 shut down
        outputEnable = 2'b10;
        for (int r = 0; r < 8; r++)
        begin
            phasesInRail = 3'(r);
            repeat (2) @(posedge clk_sys);
            #1;
            chk(16'({comp, mpMode, softOff, fallUsed}), (r == 3) ? 16'h04 : 16'h1b);
            chk(16'({hsOe, lsLow}), (r == 3) ? 16'h9 : 16'hc);
        end
        outputEnable = 2'b11;
        phasesInRail = RAIL_FOUR_PHASE;
        good_time(16'h0000, PGOOD_DELAY_RESET);
        good_time(16'h0001, 16'h0400);
        // each fault source against a random mask
        wr(3, 16'($urandom));
        for (int i = 0; i < 16; i++)
        begin
            faultEvents[i] = 1'b1;
            @(posedge clk_sys);
            #1;
            chk(16'(capEv), 16'(model[3][i] == 0 && FAULT_USED_BITS[i]));
            if (capEv === 1'b1)
                chk(capSrc, 16'h1 << i);
            faultEvents[i] = 1'b0;
            @(posedge clk_sys);
            #1;
        end
        complete_run();
    end
endmodule // tb_pgdr_regs
